// ===== logic/msx_ctrl.v
// Overview of operation
// - address phase lanes: 0 single, 1 and 2 multi-lane, 3 reserved as single
// - xip data lanes: 1 dual, 2 quad, 3 octal, 0 reserved as single
// - select bits drive active-low select lines only from transfer start
// - select register writes ignored while busy or enabled
// - reading xip overflow clear returns status and clears it; writes do nothing
// - continuous mode deselects after hclk timeout; timeout locked while enabled
// - master starts all transfers; disabled means idle, clock held low
// - serial clock is core clock over even divider; zero stops it
// - serial clock at most half core clock; sample rise, drive fall
// - 32-bit fifos, frames 4 to 32 bits, right-justified
// - data writes push transmit fifo; shifter pops it
// - data reads pop receive fifo; shifter pushes frames
// - transmit empty flag while level at or below threshold
// - write to full transmit fifo dropped, sticky overflow, read clears
// - receive full flag while level at least threshold plus one
// - frame into full receive fifo dropped, sticky overflow, read clears
// - read of empty receive fifo gives zero, sticky underflow, read clears
// - interrupt output is or of masked sources
// - dma enable bits turn on transmit and receive handshakes
// - data writes need enable; clearing enable empties both fifos
`timescale 1ns/1ps
`include "msx_map.vh"
module msx_ctrl (
    // clock and reset
    input  wire        clock_i,
    input  wire        reset_n_i,
    // ahb slave
    input  wire        hsel_i,
    input  wire [31:0] haddr_i,
    input  wire [1:0]  htrans_i,
    input  wire        hwrite_i,
    input  wire [31:0] hwdata_i,
    input  wire        hready_i,
    output reg  [31:0] hrdata_o,
    output reg         hready_o,
    output reg         hresp_o,
    // serial link
    output reg         sclk_o,
    output reg  [15:0] ss_n_o,
    output reg  [7:0]  txd_o,
    output reg  [7:0]  txd_oe_o,
    input  wire [7:0]  rxd_i,
    // execute-in-place requests
    input  wire        xip_req_i,
    input  wire [31:0] xip_addr_i,
    output reg         xip_busy_o,
    output reg         xip_done_o,
    output reg  [31:0] xip_rdata_o,
    // interrupt and dma
    output reg         intr_o,
    output reg         dma_tx_req_o,
    output reg         dma_rx_req_o
);
    localparam [2:0] ST_IDLE = 3'd0;
    localparam [2:0] ST_FRAME = 3'd1;
    localparam [2:0] ST_XADDR = 3'd2;
    localparam [2:0] ST_XDATA = 3'd3;
    localparam [2:0] ST_HOLD = 3'd4;

    // lane count of a format code
    function [3:0] lanes_of;
        input [1:0] fmt;
        begin
            case (fmt)
                2'd1: lanes_of = 4'd2;
                2'd2: lanes_of = 4'd4;
                2'd3: lanes_of = 4'd8;
                default: lanes_of = 4'd1;
            endcase
        end
    endfunction

    // shift data left by the lane count
    function [31:0] sh_step;
        input [31:0] v;
        input [3:0]  l;
        begin
            sh_step = v << l;
        end
    endfunction

    // top bits of the shifter onto the lanes, lane 0 carries the lowest
    function [7:0] lane_out;
        input [31:0] v;
        input [3:0]  l;
        begin
            case (l)
                4'd2: lane_out = {6'h00, v[31:30]};
                4'd4: lane_out = {4'h0, v[31:28]};
                4'd8: lane_out = v[31:24];
                default: lane_out = {7'h00, v[31]};
            endcase
        end
    endfunction

    // registers
    reg  [4:0]  frame_len_q;
    reg         unit_on_q;
    reg  [15:0] div_q;
    reg  [2:0]  tx_thr_q, rx_thr_q;
    reg  [5:0]  mask_q;
    reg         tx_dma_on_q, rx_dma_on_q;
    reg  [1:0]  lane_frame_format_q, cmd_addr_lane_choice_q;
    reg         cont_on_q;
    reg  [15:0] target_select_q;
    reg  [7:0]  tout_q;
    reg         txo_q, rxo_q, rxu_q, xrxo_q;
    // bus phase
    reg         ap_wr_q;
    reg  [11:0] ap_addr_q;
    // fifos
    reg  [31:0] txf_q [0:`MSX_FIFO_DEPTH-1];
    reg  [31:0] rxf_q [0:`MSX_FIFO_DEPTH-1];
    reg  [`MSX_PTR_W-1:0] tx_wp_q, tx_rp_q, rx_wp_q, rx_rp_q;
    reg  [`MSX_CNT_W-1:0] tx_cnt_q, rx_cnt_q;
    // shifter
    reg  [2:0]  st_q;
    reg  [31:0] sh_q, rsh_q;
    reg  [5:0]  bits_q;
    reg  [3:0]  lanes_q;
    reg  [14:0] dcnt_q;
    reg  [7:0]  tmr_q;
    reg         frame_done;
    reg  [31:0] rsh_nx;
    reg  [31:0] rd_d;
    wire        buf_valid, buf_in_ready;
    wire [31:0] buf_data;
    wire        ap_take = hsel_i & hready_i & htrans_i[1];
    wire [11:0] a = haddr_i[11:0];
    wire        rd = ap_take & ~hwrite_i;
    wire        dp_wr = ap_wr_q;
    wire        tx_full = (tx_cnt_q == `MSX_FIFO_DEPTH);
    wire        rx_full = (rx_cnt_q == `MSX_FIFO_DEPTH);
    wire        busy = (st_q != ST_IDLE) | (tx_cnt_q != 0) | buf_valid;
    wire        txe = ({1'b0, tx_cnt_q} <= {2'b00, tx_thr_q});
    wire        rxf = ({1'b0, rx_cnt_q} >= {2'b00, rx_thr_q} + 5'd1);
    wire [5:0]  raw = {xrxo_q, rxf, rxo_q, rxu_q, txo_q, txe};
    wire        tick = (dcnt_q == div_q[15:1] - 15'd1);
    wire        can_run = unit_on_q & (div_q[15:1] != 15'd0);
    wire        start_frame = (st_q == ST_IDLE) & can_run & ~xip_req_i & buf_valid;
    wire        tx_push = dp_wr & (ap_addr_q == `MSX_OFF_FIFO_WIN) & unit_on_q;
    wire        tx_pop = buf_in_ready & (tx_cnt_q != 0);
    wire        rx_pop = rd & (a == `MSX_OFF_FIFO_WIN) & (rx_cnt_q != 0);
    wire        rx_push = frame_done & ~rx_full;

    // transmit fifo feeds the shifter through a two-entry buffer
    msx_skid u_skid (
        .clock_i     (clock_i),
        .reset_n_i   (reset_n_i),
        .flush_i     (~unit_on_q),
        .in_valid_i  (tx_cnt_q != 0),
        .in_ready_o  (buf_in_ready),
        .in_data_i   (txf_q[tx_rp_q]),
        .out_valid_o (buf_valid),
        .out_ready_i (start_frame),
        .out_data_o  (buf_data)
    );

    // read data mux, evaluated in the address phase
    always @* begin
        rd_d = 32'h0000_0000;
        case (a)
            `MSX_OFF_CTRL:     rd_d = {27'h0, frame_len_q};
            `MSX_OFF_UNIT_ON:  rd_d = {31'h0, unit_on_q};
            `MSX_OFF_DIVIDER:  rd_d = {16'h0, div_q};
            `MSX_OFF_TX_THR:   rd_d = {29'h0, tx_thr_q};
            `MSX_OFF_RX_THR:   rd_d = {29'h0, rx_thr_q};
            `MSX_OFF_TX_LEVEL: rd_d = {28'h0, tx_cnt_q};
            `MSX_OFF_RX_LEVEL: rd_d = {28'h0, rx_cnt_q};
            `MSX_OFF_STATUS:   rd_d = {27'h0, rx_full, rx_cnt_q != 0, tx_cnt_q == 0, ~tx_full, busy};
            `MSX_OFF_INT_MASK: rd_d = {26'h0, mask_q};
            `MSX_OFF_INT_STAT: rd_d = {26'h0, raw & mask_q};
            `MSX_OFF_INT_RAW:  rd_d = {26'h0, raw};
            `MSX_OFF_TXO_CLR:  rd_d = {31'h0, txo_q};
            `MSX_OFF_RXO_CLR:  rd_d = {31'h0, rxo_q};
            `MSX_OFF_RXU_CLR:  rd_d = {31'h0, rxu_q};
            `MSX_OFF_DMA_CTRL: rd_d = {30'h0, tx_dma_on_q, rx_dma_on_q};
            `MSX_OFF_FIFO_WIN: rd_d = (rx_cnt_q != 0) ? rxf_q[rx_rp_q] : 32'h0000_0000;
            `MSX_OFF_XIP_CTRL: rd_d = {27'h0, cont_on_q, cmd_addr_lane_choice_q, lane_frame_format_q};
            `MSX_OFF_XIP_SEL:  rd_d = {16'h0, target_select_q};
            `MSX_OFF_XRXO_CLR: rd_d = {31'h0, xrxo_q};
            `MSX_OFF_XIP_TOUT: rd_d = {24'h0, tout_q};
            default:           rd_d = 32'h0000_0000;
        endcase
    end

    // bus slave: address phase latch, read data and write data phase
    always @(posedge clock_i) begin
        if (!reset_n_i) begin
            ap_wr_q  <= 1'b0;
            ap_addr_q <= 12'h000;
            hrdata_o <= 32'h0000_0000;
            hready_o <= 1'b0;
            hresp_o  <= 1'b0;
        end else begin
            hready_o  <= 1'b1;
            hresp_o   <= 1'b0;
            ap_wr_q   <= ap_take & hwrite_i;
            ap_addr_q <= a;
            if (rd)
                hrdata_o <= rd_d;
        end
    end

    // software registers
    always @(posedge clock_i) begin
        if (!reset_n_i) begin
            frame_len_q <= `MSX_RST_CTRL;
            unit_on_q <= 1'b0;
            div_q <= `MSX_RST_DIV;
            tx_thr_q <= 3'h0;
            rx_thr_q <= 3'h0;
            mask_q <= `MSX_RST_MASK;
            tx_dma_on_q <= 1'b0;
            rx_dma_on_q <= 1'b0;
            lane_frame_format_q <= 2'h0;
            cmd_addr_lane_choice_q <= 2'h0;
            cont_on_q <= 1'b0;
            target_select_q <= 16'h0000;
            tout_q <= `MSX_RST_TOUT;
        end else if (dp_wr) begin
            case (ap_addr_q)
                `MSX_OFF_CTRL:     frame_len_q <= (hwdata_i[4:0] < 5'd3) ? 5'd3 : hwdata_i[4:0];
                `MSX_OFF_UNIT_ON:  unit_on_q <= hwdata_i[0];
                `MSX_OFF_DIVIDER:  div_q <= {hwdata_i[15:1], 1'b0};
                `MSX_OFF_TX_THR:   tx_thr_q <= hwdata_i[2:0];
                `MSX_OFF_RX_THR:   rx_thr_q <= hwdata_i[2:0];
                `MSX_OFF_INT_MASK: mask_q <= hwdata_i[5:0];
                `MSX_OFF_DMA_CTRL: begin
                    rx_dma_on_q <= hwdata_i[0];
                    tx_dma_on_q <= hwdata_i[1];
                end
                `MSX_OFF_XIP_CTRL: begin
                    lane_frame_format_q <= hwdata_i[1:0];
                    cmd_addr_lane_choice_q <= hwdata_i[3:2];
                    cont_on_q <= hwdata_i[4];
                end
                `MSX_OFF_XIP_SEL: if (!busy && !unit_on_q) target_select_q <= hwdata_i[15:0];
                `MSX_OFF_XIP_TOUT: if (!unit_on_q) tout_q <= hwdata_i[7:0];
                default: ;
            endcase
        end
    end

    // sticky flags: a set in the cycle of the clearing read wins
    always @(posedge clock_i) begin
        if (!reset_n_i) begin
            txo_q <= 1'b0;
            rxo_q <= 1'b0;
            rxu_q <= 1'b0;
            xrxo_q <= 1'b0;
        end else begin
            txo_q <= (tx_push & tx_full) | (txo_q & ~(rd & (a == `MSX_OFF_TXO_CLR)));
            rxo_q <= (frame_done & rx_full & (st_q == ST_FRAME)) |
                     (rxo_q & ~(rd & (a == `MSX_OFF_RXO_CLR)));
            rxu_q <= (rd & (a == `MSX_OFF_FIFO_WIN) & (rx_cnt_q == 0)) |
                     (rxu_q & ~(rd & (a == `MSX_OFF_RXU_CLR)));
            xrxo_q <= (frame_done & rx_full & (st_q == ST_XDATA)) |
                      (xrxo_q & ~(rd & (a == `MSX_OFF_XRXO_CLR)));
        end
    end

    // fifos; disabling the unit empties both
    always @(posedge clock_i) begin
        if (!reset_n_i || !unit_on_q) begin
            tx_wp_q <= 3'd0;
            tx_rp_q <= 3'd0;
            tx_cnt_q <= 4'd0;
            rx_wp_q <= 3'd0;
            rx_rp_q <= 3'd0;
            rx_cnt_q <= 4'd0;
        end else begin
            if (tx_push && !tx_full) begin
                txf_q[tx_wp_q] <= hwdata_i;
                tx_wp_q <= tx_wp_q + 1'b1;
            end
            if (tx_pop)
                tx_rp_q <= tx_rp_q + 1'b1;
            tx_cnt_q <= tx_cnt_q + {3'b0, tx_push & ~tx_full} - {3'b0, tx_pop};
            if (rx_push) begin
                rxf_q[rx_wp_q] <= rsh_nx;
                rx_wp_q <= rx_wp_q + 1'b1;
            end
            if (rx_pop)
                rx_rp_q <= rx_rp_q + 1'b1;
            rx_cnt_q <= rx_cnt_q + {3'b0, rx_push} - {3'b0, rx_pop};
        end
    end

    // receive shift value and end of frame on the driving edge
    always @* begin
        rsh_nx = rsh_q; // value pushed is the completed frame
        frame_done = ((st_q == ST_FRAME) || (st_q == ST_XDATA)) & tick & sclk_o &
                     ({2'b00, lanes_q} >= bits_q);
    end

    // serial engine
    always @(posedge clock_i) begin
        if (!reset_n_i || !unit_on_q) begin
            st_q <= ST_IDLE;
            sclk_o <= 1'b0;
            ss_n_o <= 16'hffff;
            txd_o <= 8'h00;
            txd_oe_o <= 8'h00;
            sh_q <= 32'h0;
            rsh_q <= 32'h0;
            bits_q <= 6'd0;
            lanes_q <= 4'd1;
            dcnt_q <= 15'd0;
            tmr_q <= 8'h00;
            xip_busy_o <= 1'b0;
            xip_done_o <= 1'b0;
            xip_rdata_o <= 32'h0;
        end else begin
            xip_done_o <= 1'b0;
            if (st_q != ST_IDLE && st_q != ST_HOLD)
                dcnt_q <= tick ? 15'd0 : dcnt_q + 15'd1;
            else
                dcnt_q <= 15'd0;
            case (st_q)
                ST_IDLE: begin
                    ss_n_o <= 16'hffff;
                    if (can_run && xip_req_i) begin
                        st_q <= ST_XADDR;
                        ss_n_o <= ~target_select_q;
                        lanes_q <= (cmd_addr_lane_choice_q == 2'd3) ? 4'd1 :
                                   (cmd_addr_lane_choice_q == 2'd0) ? 4'd1 :
                                   lanes_of(lane_frame_format_q);
                        sh_q <= xip_addr_i;
                        bits_q <= 6'd32;
                        txd_o <= lane_out(xip_addr_i, (cmd_addr_lane_choice_q[1] ^ cmd_addr_lane_choice_q[0]) ?
                                 lanes_of(lane_frame_format_q) : 4'd1);
                        txd_oe_o <= 8'hff;
                        tmr_q <= tout_q;
                        xip_busy_o <= 1'b1;
                    end else if (start_frame) begin
                        st_q <= ST_FRAME;
                        ss_n_o <= ~target_select_q;
                        lanes_q <= 4'd1;
                        sh_q <= buf_data << (6'd31 - {1'b0, frame_len_q});
                        bits_q <= {1'b0, frame_len_q} + 6'd1;
                        txd_o <= lane_out(buf_data << (6'd31 - {1'b0, frame_len_q}), 4'd1);
                        txd_oe_o <= 8'h01;
                    end
                end
                ST_FRAME, ST_XADDR, ST_XDATA: begin
                    if (tick) begin
                        sclk_o <= ~sclk_o;
                        if (!sclk_o) begin
                            case (lanes_q) // sample on the rising edge
                                4'd2: rsh_q <= {rsh_q[29:0], rxd_i[1:0]};
                                4'd4: rsh_q <= {rsh_q[27:0], rxd_i[3:0]};
                                4'd8: rsh_q <= {rsh_q[23:0], rxd_i};
                                default: rsh_q <= {rsh_q[30:0], rxd_i[0]};
                            endcase
                        end else if ({2'b00, lanes_q} < bits_q) begin
                            bits_q <= bits_q - {2'b00, lanes_q};
                            sh_q <= sh_step(sh_q, lanes_q);
                            txd_o <= lane_out(sh_step(sh_q, lanes_q), lanes_q);
                        end else if (st_q == ST_XADDR) begin
                            st_q <= ST_XDATA;
                            lanes_q <= lanes_of(lane_frame_format_q);
                            bits_q <= 6'd32;
                            rsh_q <= 32'h0;
                            txd_oe_o <= 8'h00;
                        end else begin
                            txd_oe_o <= 8'h00;
                            rsh_q <= 32'h0;
                            if (st_q == ST_XDATA) begin
                                xip_rdata_o <= rsh_q;
                                xip_done_o <= 1'b1;
                                xip_busy_o <= 1'b0;
                            end
                            if (st_q == ST_XDATA && cont_on_q) begin
                                st_q <= ST_HOLD;
                                tmr_q <= tout_q;
                            end else begin
                                st_q <= ST_IDLE;
                                ss_n_o <= 16'hffff;
                            end
                        end
                    end
                end
                ST_HOLD: begin
                    if (xip_req_i && can_run) begin
                        st_q <= ST_XDATA; // command and address not resent
                        lanes_q <= lanes_of(lane_frame_format_q);
                        bits_q <= 6'd32;
                        tmr_q <= tout_q;
                        xip_busy_o <= 1'b1;
                    end else if (tmr_q == 8'h00) begin
                        st_q <= ST_IDLE;
                        ss_n_o <= 16'hffff;
                    end else begin
                        tmr_q <= tmr_q - 8'h01;
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // interrupt and dma handshake outputs
    always @(posedge clock_i) begin
        if (!reset_n_i) begin
            intr_o <= 1'b0;
            dma_tx_req_o <= 1'b0;
            dma_rx_req_o <= 1'b0;
        end else begin
            intr_o <= |(raw & mask_q);
            dma_tx_req_o <= tx_dma_on_q & unit_on_q & txe;
            dma_rx_req_o <= rx_dma_on_q & unit_on_q & rxf;
        end
    end
endmodule

// ===== logic/msx_map.vh
`ifndef MSX_MAP_VH
`define MSX_MAP_VH

// register byte offsets, decoded from haddr[11:0]
`define MSX_OFF_CTRL      12'h000
`define MSX_OFF_UNIT_ON   12'h008
`define MSX_OFF_DIVIDER   12'h014
`define MSX_OFF_TX_THR    12'h018
`define MSX_OFF_RX_THR    12'h01c
`define MSX_OFF_TX_LEVEL  12'h020
`define MSX_OFF_RX_LEVEL  12'h024
`define MSX_OFF_STATUS    12'h028
`define MSX_OFF_INT_MASK  12'h02c
`define MSX_OFF_INT_STAT  12'h030
`define MSX_OFF_INT_RAW   12'h034
`define MSX_OFF_TXO_CLR   12'h038
`define MSX_OFF_RXO_CLR   12'h03c
`define MSX_OFF_RXU_CLR   12'h040
`define MSX_OFF_DMA_CTRL  12'h04c
`define MSX_OFF_FIFO_WIN  12'h060
`define MSX_OFF_XIP_CTRL  12'h108
`define MSX_OFF_XIP_SEL   12'h10c
`define MSX_OFF_XRXO_CLR  12'h110
`define MSX_OFF_XIP_TOUT  12'h114

// interrupt bit positions
`define MSX_INT_TXE   0
`define MSX_INT_TXO   1
`define MSX_INT_RXU   2
`define MSX_INT_RXO   3
`define MSX_INT_RXF   4
`define MSX_INT_XRXO  5

// reset values
`define MSX_RST_CTRL   5'h07
`define MSX_RST_MASK   6'h3f
`define MSX_RST_DIV    16'h0000
`define MSX_RST_TOUT   8'h00

// fifo depth and level width
`define MSX_FIFO_DEPTH 8
`define MSX_PTR_W      3
`define MSX_CNT_W      4

`endif

// ===== logic/msx_skid.v
`timescale 1ns/1ps
// two-entry buffer between the transmit fifo and the shifter
module msx_skid (
    // clock and reset
    input  wire        clock_i,
    input  wire        reset_n_i,
    input  wire        flush_i,
    // filling side
    input  wire        in_valid_i,
    output wire        in_ready_o,
    input  wire [31:0] in_data_i,
    // draining side
    output wire        out_valid_o,
    input  wire        out_ready_i,
    output wire [31:0] out_data_o
);
    reg [31:0] mem_q [0:1];
    reg        wp_q;
    reg        rp_q;
    reg [1:0]  cnt_q;
    wire       push;
    wire       pop;

    assign in_ready_o  = (cnt_q != 2'd2);
    assign out_valid_o = (cnt_q != 2'd0);
    assign out_data_o  = mem_q[rp_q];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    // pointers and count
    always @(posedge clock_i) begin
        if (!reset_n_i || flush_i) begin
            wp_q  <= 1'b0;
            rp_q  <= 1'b0;
            cnt_q <= 2'd0;
        end else begin
            if (push)
                wp_q <= ~wp_q;
            if (pop)
                rp_q <= ~rp_q;
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end

    // storage
    always @(posedge clock_i) begin
        if (push)
            mem_q[wp_q] <= in_data_i;
    end
endmodule

// ===== bench/msx_checker.sv
`timescale 1ns/1ps
module msx_checker (
    // core clock and reset
    input wire        clock_i,
    input wire        reset_n_i,
    // bus answer and serial link
    input wire        hready_o,
    input wire        hresp_o,
    input wire        sclk_o,
    input wire [15:0] ss_n_o,
    input wire [7:0]  txd_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);
    // all selects high means no frame
    wire idle = &ss_n_o;
    // link timing
    property p_idle_clk; idle |-> !sclk_o; endproperty
    a_idle_clk: assert property (p_idle_clk) else $error("clock runs while deselected");
    property p_start; $fell(idle) |-> !sclk_o; endproperty
    a_start: assert property (p_start) else $error("frame starts with clock high");
    property p_gap; $rose(idle) |-> !sclk_o; endproperty
    a_gap: assert property (p_gap) else $error("frame ends with clock high");
    property p_rise; $rose(sclk_o) |-> $stable(txd_o); endproperty
    a_rise: assert property (p_rise) else $error("data moves on sampling edge");
    property p_drive; $changed(txd_o) && !idle && !$fell(idle) |-> $fell(sclk_o); endproperty
    a_drive: assert property (p_drive) else $error("data moves off the falling edge");
    property p_sel; $changed(ss_n_o) && !idle |-> $past(idle); endproperty
    a_sel: assert property (p_sel) else $error("select changed inside a frame");
    // bus answer
    property p_ready; $past(reset_n_i) |-> hready_o; endproperty
    a_ready: assert property (p_ready) else $error("bus stalled");
    property p_okay; $past(reset_n_i) |-> !hresp_o; endproperty
    a_okay: assert property (p_okay) else $error("bus error answer");
    c_frame: cover property ($fell(idle));
    c_clock: cover property ($rose(sclk_o));
    c_end: cover property ($rose(idle));
endmodule

bind msx_ctrl msx_checker chk_u (.clock_i(clock_i), .reset_n_i(reset_n_i), .hready_o(hready_o),
    .hresp_o(hresp_o), .sclk_o(sclk_o), .ss_n_o(ss_n_o), .txd_o(txd_o));

// ===== bench/msx_slave_model.sv
`timescale 1ns/1ps
module msx_slave_model #(
    parameter [31:0] RESP = 32'h3c5a9617
) (
    // link from the master
    input  wire        sclk_i,
    input  wire [15:0] ss_n_i,
    input  wire [7:0]  txd_i,
    // answer and captured bits
    output reg  [7:0]  rxd_o,
    output reg  [31:0] mosi_o
);
    reg  [31:0] sh_q;
    reg         last_q;
    wire        sel = ~&ss_n_i;
    initial begin
        sh_q = RESP;
        last_q = 1'b0;
        mosi_o = 32'h0;
    end
    // fresh answer at each selection
    always @(posedge sel) begin
        sh_q = RESP;
        mosi_o = 32'h0;
    end
    // shift out on falling, capture on rising
    always @(negedge sclk_i) if (sel) sh_q = {sh_q[30:0], sh_q[31]};
    always @(posedge sclk_i) if (sel) mosi_o = {mosi_o[30:0], txd_i[0]};
    // released lines show the inverse of the last bit
    always @* begin
        if (sel) begin
            rxd_o = {8{sh_q[31]}};
            last_q = sh_q[31];
        end else rxd_o = {8{~last_q}};
    end
endmodule

// ===== bench/tb_multi_lane_spi_master_xip.sv
`timescale 1ns/1ps
`include "msx_map.vh"
module tb_multi_lane_spi_master_xip;
    reg         clock_i, reset_n_i, hsel_i, hwrite_i, xreq;
    reg  [1:0]  htrans_i;
    reg  [31:0] haddr_i, hwdata_i, rdv, hi_cnt, hi_len;
    wire [31:0] hrdata_o, mosi, xrd;
    wire [15:0] ss_n_o;
    wire [7:0]  txd_o, rxd_i;
    wire        sclk_o, intr_o, dma_tx;
    integer     n_errors, num_checks, cyc, i;
    msx_ctrl dut_u (.clock_i(clock_i), .reset_n_i(reset_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
        .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hwdata_i(hwdata_i), .hready_i(1'b1), .hrdata_o(hrdata_o),
        .hready_o(), .hresp_o(), .sclk_o(sclk_o), .ss_n_o(ss_n_o), .txd_o(txd_o), .txd_oe_o(), .rxd_i(rxd_i),
        .xip_req_i(xreq), .xip_addr_i(32'h0), .xip_busy_o(), .xip_done_o(), .xip_rdata_o(xrd),
        .intr_o(intr_o), .dma_tx_req_o(dma_tx), .dma_rx_req_o());
    msx_slave_model mdl_u (.sclk_i(sclk_o), .ss_n_i(ss_n_o), .txd_i(txd_o), .rxd_o(rxd_i), .mosi_o(mosi));
    task close_out;
        begin
            $display("checks %0d errors %0d", num_checks, n_errors);
            if (n_errors == 0 && num_checks > 0) begin
                $display("bench passed");
            end else begin
                $display("bench failed");
            end
            $finish;
        end
    endtask
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            num_checks = num_checks + 1;
            if (seen !== exp) begin
                n_errors = n_errors + 1;
                $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    // one bus access: address phase, data phase, settle
    task acc(input w, input [11:0] a, input [31:0] d);
        begin
            @(negedge clock_i);
            hsel_i = 1'b1;
            htrans_i = 2'h2;
            hwrite_i = w;
            haddr_i = {20'h0, a};
            @(negedge clock_i);
            hsel_i = 1'b0;
            htrans_i = 2'h0;
            hwdata_i = d;
            @(negedge clock_i);
            rdv = hrdata_o;
            @(negedge clock_i);
        end
    endtask
    task wr(input [11:0] a, input [31:0] d);
        acc(1'b1, a, d);
    endtask
    task rc(input [11:0] a, input [31:0] e);
        begin
            acc(1'b0, a, 32'h0);
            chk(rdv, e);
        end
    endtask
    task rb(input integer b, input e);
        begin
            acc(1'b0, `MSX_OFF_INT_RAW, 32'h0);
            chk({31'h0, rdv[b]}, {31'h0, e});
        end
    endtask
    task drain;
        integer k;
        for (k = 0; k < 400; k = k + 1) begin
            acc(1'b0, `MSX_OFF_STATUS, 32'h0);
            if (rdv[0] === 1'b0 && rdv[2] === 1'b1) k = 400;
        end
    endtask
    // clock and timeout
    initial begin
        clock_i = 1'b0;
        forever #50 clock_i = ~clock_i;
    end
    always @(posedge clock_i) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            n_errors = n_errors + 1;
            close_out;
        end
    end
    // length of each high phase of the serial clock
    always @(posedge clock_i) begin
        if (sclk_o) hi_cnt <= hi_cnt + 32'h1;
        else if (hi_cnt != 32'h0) begin
            hi_len <= hi_cnt;
            hi_cnt <= 32'h0;
        end
    end
    initial begin
        {xreq, reset_n_i, hsel_i, hwrite_i, htrans_i, haddr_i, hwdata_i, hi_cnt, hi_len} = 0;
        n_errors = 0;
        num_checks = 0;
        cyc = 0;
        repeat (20) @(negedge clock_i);
        reset_n_i = 1'b1;
        // locks while enabled
        rc(`MSX_OFF_XIP_TOUT, 32'h0);
        wr(`MSX_OFF_XIP_TOUT, 32'h2a);
        rc(`MSX_OFF_XIP_TOUT, 32'h2a);
        wr(`MSX_OFF_XIP_SEL, 32'h1);
        rc(`MSX_OFF_XIP_SEL, 32'h1);
        wr(`MSX_OFF_UNIT_ON, 32'h1);
        wr(`MSX_OFF_XIP_TOUT, 32'h55);
        rc(`MSX_OFF_XIP_TOUT, 32'h2a);
        wr(`MSX_OFF_XIP_SEL, 32'h2);
        rc(`MSX_OFF_XIP_SEL, 32'h1);
        $display("test locks done");
        // underflow, combined interrupt, dma
        rc(`MSX_OFF_FIFO_WIN, 32'h0);
        rb(`MSX_INT_RXU, 1'b1);
        acc(1'b0, `MSX_OFF_RXU_CLR, 32'h0);
        rb(`MSX_INT_RXU, 1'b0);
        chk({31'h0, intr_o}, 32'h1);
        wr(`MSX_OFF_INT_MASK, 32'h0);
        chk({31'h0, intr_o}, 32'h0);
        chk({31'h0, dma_tx}, 32'h0);
        wr(`MSX_OFF_DMA_CTRL, 32'h2);
        chk({31'h0, dma_tx}, 32'h1);
        $display("test flags done");
        // one 8-bit frame each way
        wr(`MSX_OFF_UNIT_ON, 32'h0);
        wr(`MSX_OFF_CTRL, 32'h7);
        wr(`MSX_OFF_DIVIDER, 32'h4);
        wr(`MSX_OFF_UNIT_ON, 32'h1);
        wr(`MSX_OFF_FIFO_WIN, 32'ha5);
        drain;
        chk({24'h0, mosi[7:0]}, 32'ha5);
        chk(hi_len, 32'h2);
        rc(`MSX_OFF_RX_LEVEL, 32'h1);
        rc(`MSX_OFF_FIFO_WIN, 32'h3c);
        $display("test frame done");
        // transmit overflow with the clock stopped
        wr(`MSX_OFF_DIVIDER, 32'h0);
        for (i = 0; i < 11; i = i + 1) wr(`MSX_OFF_FIFO_WIN, i);
        rb(`MSX_INT_TXO, 1'b1);
        rb(`MSX_INT_TXE, 1'b0);
        chk({31'h0, sclk_o}, 32'h0);
        acc(1'b0, `MSX_OFF_TXO_CLR, 32'h0);
        rb(`MSX_INT_TXO, 1'b0);
        wr(`MSX_OFF_UNIT_ON, 32'h0);
        rc(`MSX_OFF_TX_LEVEL, 32'h0);
        wr(`MSX_OFF_FIFO_WIN, 32'h1);
        rc(`MSX_OFF_TX_LEVEL, 32'h0);
        rb(`MSX_INT_TXE, 1'b1);
        $display("test tx overflow done");
        // receive overflow with 4-bit frames
        wr(`MSX_OFF_CTRL, 32'h3);
        wr(`MSX_OFF_DIVIDER, 32'h2);
        wr(`MSX_OFF_UNIT_ON, 32'h1);
        for (i = 0; i < 10; i = i + 1) wr(`MSX_OFF_FIFO_WIN, i);
        drain;
        rb(`MSX_INT_RXO, 1'b1);
        rb(`MSX_INT_RXF, 1'b1);
        acc(1'b0, `MSX_OFF_RXO_CLR, 32'h0);
        rb(`MSX_INT_RXO, 1'b0);
        for (i = 0; i < 8; i = i + 1) rc(`MSX_OFF_FIFO_WIN, 32'h3);
        rb(`MSX_INT_RXF, 1'b0);
        rb(`MSX_INT_RXU, 1'b0);
        $display("test rx overflow done");
        // one single-lane xip read
        xreq = 1'b1;
        @(negedge clock_i) xreq = 1'b0;
        repeat (150) @(negedge clock_i);
        chk(xrd, mdl_u.RESP);
        $display("test xip done");
        close_out;
    end
endmodule
